// [src/exec_map.vh]
`ifndef EXEC_MAP_VH
`define EXEC_MAP_VH

// register port offsets (word index on the plain port)
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_MASK 4'h2
`define REG_ACC 4'h3
`define REG_SEL 4'h4
`define REG_RFILE 4'h5

// control register fields
`define CTRL_IE_BIT 0
`define CTRL_X_LSB 4
`define CTRL_P_LSB 8
`define CTRL_DF_BIT 12

// status / mask bits
`define EV_EXEC_DONE 0
`define EV_DMA_IN 1
`define EV_DMA_OUT 2
`define EV_INT_ENTRY 3
`define EV_WIDTH 4

// opcode low nibbles of the final group
`define OP_LOAD_VIA_X 4'h0
`define OP_OR 4'h1
`define OP_AND 4'h2
`define OP_XOR 4'h3
`define OP_ADD 4'h4
`define OP_SUB_ACC_FROM_MEM 4'h5
`define OP_SHIFT_RIGHT 4'h6
`define OP_SUB_MEM_FROM_ACC 4'h7
`define OP_SHIFT_LEFT 4'he

// selector values forced at interrupt entry, and the register index used as the dma pointer
`define INT_P_VALUE 4'h1
`define INT_X_VALUE 4'h2
`define DMA_PTR_INDEX 4'h0

// cycles a memory access spends in the access state; the write-back cycle after them takes the byte
`define ACCESS_CYCLES 3'h4

// reset values
`define RST_ACC 8'h00
`define RST_ADDR 16'h0000

`endif

// [src/exec_unit.v]
`timescale 1ns/1ps
`include "exec_map.vh"

module exec_unit (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // instruction request from the fetch/decode logic (same clock)
  input wire exec_start,
  input wire [3:0] exec_op,
  output reg exec_busy,
  output reg exec_done,
  // external request pins
  input wire dma_in_req_pin,
  input wire dma_out_req_pin,
  input wire int_req_pin,
  input wire clear_n,
  input wire wait_n,
  // memory bus
  output reg [15:0] mem_addr,
  input wire [7:0] mem_data_in,
  output reg mem_read_strobe_n,
  output reg mem_write_strobe_n,
  output reg timing_pulse_a,
  // register port
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // interrupt
  output reg irq
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_ACCESS = 4'b0010;
  localparam [3:0] ST_WB = 4'b0100;
  localparam [3:0] ST_LOAD = 4'b1000;

  localparam [3:0] K_EXEC = 4'b0001;
  localparam [3:0] K_DMA_IN = 4'b0010;
  localparam [3:0] K_DMA_OUT = 4'b0100;
  localparam [3:0] K_INT = 4'b1000;

  // two-flop synchronisers for every pin input
  reg [4:0] pin_meta_r;
  reg [4:0] pin_sync_r;
  reg [7:0] data_meta_r;
  reg [7:0] data_sync_r;

  always @(posedge core_clk) begin
    if (rst) begin
      pin_meta_r <= 5'h1_8;
      pin_sync_r <= 5'h1_8;
      data_meta_r <= 8'h00;
      data_sync_r <= 8'h00;
    end else begin
      pin_meta_r <= {clear_n, wait_n, int_req_pin, dma_out_req_pin, dma_in_req_pin};
      pin_sync_r <= pin_meta_r;
      data_meta_r <= mem_data_in;
      data_sync_r <= data_meta_r;
    end
  end

  wire dma_in_req = pin_sync_r[0];
  wire dma_out_req = pin_sync_r[1];
  wire int_req = pin_sync_r[2];
  wire load_mode = ~pin_sync_r[3] & ~pin_sync_r[4];

  // architectural state
  reg [15:0] rfile [0:15];
  reg [7:0] acc_r;
  reg carry_flag_r;
  reg int_enable_r;
  reg [3:0] x_sel_r;
  reg [3:0] p_sel_r;
  reg [7:0] t_reg_r;

  // cycle control
  reg [3:0] state_r;
  reg [3:0] kind_r;
  reg [3:0] op_r;
  reg [2:0] wait_cnt_r;
  reg [3:0] ptr_idx_r;

  // software registers
  reg [`EV_WIDTH-1:0] status_r;
  reg [`EV_WIDTH-1:0] mask_r;
  reg [3:0] sel_r;

  // decode of the latched op: low half uses R(X), high half the program counter
  wire op_immediate = op_r[3];
  // both shifts share the low bits 110; bit 3 only picks the direction
  wire op_is_shift = ({1'b0, op_r[2:0]} == `OP_SHIFT_RIGHT);
  wire [3:0] exec_op_idx = exec_op[3] ? p_sel_r : x_sel_r;
  // a shift never strobes memory, so the bus may hold anything meanwhile
  wire exec_op_shift = ({1'b0, exec_op[2:0]} == `OP_SHIFT_RIGHT);

  // alu: one datapath serves the indexed and immediate variants
  reg [7:0] alu_res;
  reg alu_carry;
  reg [8:0] alu_wide;

  always @* begin
    alu_res = acc_r;
    alu_carry = carry_flag_r;
    alu_wide = 9'h000;
    case (op_r[2:0])
      3'h0: begin
        alu_res = data_sync_r;
      end
      3'h1: begin
        alu_res = data_sync_r | acc_r;
      end
      3'h2: begin
        alu_res = data_sync_r & acc_r;
      end
      3'h3: begin
        alu_res = data_sync_r ^ acc_r;
      end
      3'h4: begin
        alu_wide = {1'b0, data_sync_r} + {1'b0, acc_r};
        alu_res = alu_wide[7:0];
        alu_carry = alu_wide[8];
      end
      3'h5: begin
        alu_wide = {1'b0, data_sync_r} - {1'b0, acc_r};
        alu_res = alu_wide[7:0];
        alu_carry = ~alu_wide[8];
      end
      3'h7: begin
        alu_wide = {1'b0, acc_r} - {1'b0, data_sync_r};
        alu_res = alu_wide[7:0];
        alu_carry = ~alu_wide[8];
      end
      3'h6: begin
        if (op_immediate) begin
          alu_res = {acc_r[6:0], 1'b0};
          alu_carry = acc_r[7];
        end else begin
          alu_res = {1'b0, acc_r[7:1]};
          alu_carry = acc_r[0];
        end
      end
      default: begin
        alu_res = acc_r;
      end
    endcase
  end

  // events for the status register, one cycle each
  wire wb_now = (state_r == ST_WB);
  wire ev_int = wb_now & (kind_r == K_INT);
  wire ev_dma_out = wb_now & (kind_r == K_DMA_OUT);
  wire ev_dma_in = wb_now & (kind_r == K_DMA_IN);
  wire ev_exec = wb_now & (kind_r == K_EXEC);
  wire [`EV_WIDTH-1:0] events = {ev_int, ev_dma_out, ev_dma_in, ev_exec};

  wire status_rd = reg_rd & (reg_addr == `REG_STATUS);

  // cycle sequencer
  always @(posedge core_clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      kind_r <= K_EXEC;
      op_r <= 4'h0;
      wait_cnt_r <= 3'h0;
      ptr_idx_r <= 4'h0;
      mem_addr <= `RST_ADDR;
      mem_read_strobe_n <= 1'b1;
      mem_write_strobe_n <= 1'b1;
      timing_pulse_a <= 1'b0;
      exec_busy <= 1'b0;
      exec_done <= 1'b0;
    end else begin
      timing_pulse_a <= 1'b0;
      exec_done <= 1'b0;
      case (state_r)
        ST_IDLE, ST_LOAD: begin
          mem_read_strobe_n <= 1'b1;
          mem_write_strobe_n <= 1'b1;
          wait_cnt_r <= `ACCESS_CYCLES;
          // dma input is checked before dma output
          if (dma_in_req) begin
            kind_r <= K_DMA_IN;
            ptr_idx_r <= `DMA_PTR_INDEX;
            mem_addr <= rfile[`DMA_PTR_INDEX];
            mem_write_strobe_n <= 1'b0;
            timing_pulse_a <= ~load_mode;
            state_r <= ST_ACCESS;
          end else if (dma_out_req) begin
            kind_r <= K_DMA_OUT;
            ptr_idx_r <= `DMA_PTR_INDEX;
            mem_addr <= rfile[`DMA_PTR_INDEX];
            mem_read_strobe_n <= 1'b0;
            timing_pulse_a <= ~load_mode;
            state_r <= ST_ACCESS;
          end else if (load_mode) begin
            // exec and interrupt requests are dropped here, only dma loads memory
            // parked on the byte just before the dma pointer, read held low
            mem_addr <= rfile[`DMA_PTR_INDEX] - 16'h0001;
            mem_read_strobe_n <= 1'b0;
            state_r <= ST_LOAD;
          end else if (int_req & int_enable_r) begin
            kind_r <= K_INT;
            ptr_idx_r <= p_sel_r;
            mem_addr <= rfile[p_sel_r];
            timing_pulse_a <= 1'b1;
            exec_busy <= 1'b1;
            state_r <= ST_ACCESS;
          end else if (exec_start) begin
            kind_r <= K_EXEC;
            op_r <= exec_op;
            ptr_idx_r <= exec_op_idx;
            mem_addr <= rfile[exec_op_idx];
            mem_read_strobe_n <= exec_op_shift;
            timing_pulse_a <= 1'b1;
            exec_busy <= 1'b1;
            state_r <= ST_ACCESS;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        ST_ACCESS: begin
          // the count covers the two-flop delay on the returning data byte
          if (wait_cnt_r == 3'h1) begin
            state_r <= ST_WB;
          end
          wait_cnt_r <= wait_cnt_r - 3'h1;
        end
        ST_WB: begin
          mem_read_strobe_n <= 1'b1;
          mem_write_strobe_n <= 1'b1;
          exec_busy <= 1'b0;
          exec_done <= (kind_r == K_EXEC) | (kind_r == K_INT);
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // architectural updates at write-back, software writes otherwise
  integer i;
  always @(posedge core_clk) begin
    if (rst) begin
      acc_r <= `RST_ACC;
      carry_flag_r <= 1'b0;
      int_enable_r <= 1'b0;
      x_sel_r <= 4'h0;
      p_sel_r <= 4'h0;
      t_reg_r <= 8'h00;
      sel_r <= 4'h0;
      for (i = 0; i < 16; i = i + 1) begin
        rfile[i] <= `RST_ADDR;
      end
    end else begin
      if (reg_wr) begin
        if (reg_addr == `REG_CTRL) begin
          int_enable_r <= reg_wdata[`CTRL_IE_BIT];
          x_sel_r <= reg_wdata[`CTRL_X_LSB+3:`CTRL_X_LSB];
          p_sel_r <= reg_wdata[`CTRL_P_LSB+3:`CTRL_P_LSB];
          carry_flag_r <= reg_wdata[`CTRL_DF_BIT];
        end else if (reg_addr == `REG_ACC) begin
          acc_r <= reg_wdata[7:0];
        end else if (reg_addr == `REG_SEL) begin
          sel_r <= reg_wdata[3:0];
        end else if (reg_addr == `REG_RFILE) begin
          rfile[sel_r] <= reg_wdata[15:0];
        end
      end
      // hardware write-back lands after software so it wins a collision
      if (wb_now) begin
        if (kind_r == K_EXEC) begin
          acc_r <= alu_res;
          carry_flag_r <= alu_carry;
          if (op_immediate & ~op_is_shift) begin
            rfile[ptr_idx_r] <= rfile[ptr_idx_r] + 16'h0001;
          end
        end else if ((kind_r == K_DMA_IN) | (kind_r == K_DMA_OUT)) begin
          // pointer wraps at 16 bits with no indication
          rfile[ptr_idx_r] <= rfile[ptr_idx_r] + 16'h0001;
        end else begin
          t_reg_r <= {x_sel_r, p_sel_r};
          int_enable_r <= 1'b0;
          p_sel_r <= `INT_P_VALUE;
          x_sel_r <= `INT_X_VALUE;
        end
      end
    end
  end

  // status: sticky, cleared by reading it; a same-cycle event still sets
  always @(posedge core_clk) begin
    if (rst) begin
      status_r <= {`EV_WIDTH{1'b0}};
      mask_r <= {`EV_WIDTH{1'b0}};
      irq <= 1'b0;
    end else begin
      status_r <= (status_rd ? {`EV_WIDTH{1'b0}} : status_r) | events;
      if (reg_wr & (reg_addr == `REG_MASK)) begin
        mask_r <= reg_wdata[`EV_WIDTH-1:0];
      end
      irq <= |(((status_rd ? {`EV_WIDTH{1'b0}} : status_r) | events) & mask_r);
    end
  end

  // read data stands in the cycle after the strobe only
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= 32'h0000_0000;
      if (reg_rd) begin
        if (reg_addr == `REG_CTRL) begin
          reg_rdata <= {19'h0_0000, carry_flag_r, p_sel_r, x_sel_r, 3'h0, int_enable_r};
        end else if (reg_addr == `REG_STATUS) begin
          reg_rdata <= {{(32-`EV_WIDTH){1'b0}}, status_r};
        end else if (reg_addr == `REG_MASK) begin
          reg_rdata <= {{(32-`EV_WIDTH){1'b0}}, mask_r};
        end else if (reg_addr == `REG_ACC) begin
          reg_rdata <= {16'h0000, t_reg_r, acc_r};
        end else if (reg_addr == `REG_SEL) begin
          reg_rdata <= {24'h00_0000, load_mode, state_r[0], 2'h0, sel_r};
        end else if (reg_addr == `REG_RFILE) begin
          reg_rdata <= {16'h0000, rfile[sel_r]};
        end
      end
    end
  end

endmodule // exec_unit

// [testbench/exec_checker.sv]
`timescale 1ns/1ps
module exec_checker (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // watched ports
  input wire exec_busy,
  input wire exec_done,
  input wire clear_n,
  input wire wait_n,
  input wire [15:0] mem_addr,
  input wire mem_read_strobe_n,
  input wire mem_write_strobe_n,
  input wire timing_pulse_a,
  input wire reg_rd,
  input wire [31:0] reg_rdata
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  a_strobes_never_both: assert property (mem_read_strobe_n || mem_write_strobe_n)
    else $error("both strobes low");
  a_write_strobe_hold: assert property ($fell(mem_write_strobe_n) |-> (!mem_write_strobe_n)[*5] ##1 mem_write_strobe_n)
    else $error("write strobe length wrong");
  a_read_addr_hold: assert property ($fell(mem_read_strobe_n) |=> $stable(mem_addr)[*4])
    else $error("address moved during read");
  a_busy_to_done: assert property ($rose(exec_busy) |-> ##5 exec_done)
    else $error("done not five cycles after busy");
  a_done_ends_busy: assert property (exec_done |-> !exec_busy)
    else $error("busy with done");
  a_done_single: assert property (exec_done |=> !exec_done)
    else $error("done longer than a cycle");
  a_pulse_single: assert property (timing_pulse_a |=> !timing_pulse_a)
    else $error("address pulse too long");
  a_load_no_pulse: assert property ((!clear_n && !wait_n)[*6] |-> !timing_pulse_a)
    else $error("address pulse in load mode");
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read");
  c_dma_in: cover property ($fell(mem_write_strobe_n));
  c_exec: cover property ($rose(exec_busy));
  c_load: cover property ((!clear_n && !wait_n)[*6]);
endmodule // exec_checker

bind exec_unit exec_checker chk (.core_clk(core_clk), .rst(rst), .exec_busy(exec_busy), .exec_done(exec_done),
  .clear_n(clear_n), .wait_n(wait_n), .mem_addr(mem_addr), .mem_read_strobe_n(mem_read_strobe_n),
  .mem_write_strobe_n(mem_write_strobe_n), .timing_pulse_a(timing_pulse_a), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// [testbench/mem_model.sv]
`timescale 1ns/1ps
module mem_model (
  // bus from the block
  input wire core_clk,
  input wire [15:0] mem_addr,
  input wire mem_read_strobe_n,
  input wire mem_write_strobe_n,
  // byte offered by the i/o device
  input wire [7:0] io_byte,
  // data bus
  output logic [7:0] mem_data_in
);
  logic [7:0] ram_r [0:255];
  logic [7:0] last_r = 8'h00;
  // released bus shows the inverse of the last byte so a stale sample is caught
  always @* begin
    if (!mem_read_strobe_n)
      mem_data_in = ram_r[mem_addr[7:0]];
    else if (!mem_write_strobe_n)
      mem_data_in = io_byte;
    else
      mem_data_in = ~last_r;
  end
  always @(posedge core_clk) begin
    if (!mem_read_strobe_n)
      last_r <= ram_r[mem_addr[7:0]];
    else if (!mem_write_strobe_n) begin
      last_r <= io_byte;
      ram_r[mem_addr[7:0]] <= io_byte;
    end
  end
endmodule // mem_model

// [testbench/test_exec_unit.sv]
`timescale 1ns/1ps
module test_exec_unit;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic exec_start = 1'b0;
  logic [3:0] exec_op = 4'h0;
  logic dma_in_req_pin = 1'b0;
  logic dma_out_req_pin = 1'b0;
  logic int_req_pin = 1'b0;
  logic clear_n = 1'b1;
  logic wait_n = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] io_byte = 8'h3c;
  wire exec_busy, exec_done, mem_read_strobe_n, mem_write_strobe_n, timing_pulse_a, irq;
  wire [15:0] mem_addr;
  wire [7:0] mem_data_in;
  wire [31:0] reg_rdata;
  int err_total = 0;
  int compares = 0;
  logic [31:0] rv;
  logic [8:0] ev;
  logic [15:0] seen_addr;
  always #50 core_clk = ~core_clk;
  exec_unit DUT (.core_clk(core_clk), .rst(rst), .exec_start(exec_start), .exec_op(exec_op),
    .exec_busy(exec_busy), .exec_done(exec_done), .dma_in_req_pin(dma_in_req_pin),
    .dma_out_req_pin(dma_out_req_pin), .int_req_pin(int_req_pin), .clear_n(clear_n), .wait_n(wait_n),
    .mem_addr(mem_addr), .mem_data_in(mem_data_in), .mem_read_strobe_n(mem_read_strobe_n),
    .mem_write_strobe_n(mem_write_strobe_n), .timing_pulse_a(timing_pulse_a), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  mem_model mem (.core_clk(core_clk), .mem_addr(mem_addr), .mem_read_strobe_n(mem_read_strobe_n),
    .mem_write_strobe_n(mem_write_strobe_n), .io_byte(io_byte), .mem_data_in(mem_data_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic setr(input logic [3:0] i, input logic [31:0] v);
    wr(4'h4, {28'h000_0000, i});
    wr(4'h5, v);
  endtask
  // records the address of any strobed access while waiting
  task automatic wait_done;
    int n;
    n = 0;
    seen_addr = 16'hffff;
    do begin
      @(posedge core_clk);
      #1 n++;
      if (mem_read_strobe_n !== 1'b1 || mem_write_strobe_n !== 1'b1) seen_addr = mem_addr;
    end while (exec_done !== 1'b1 && n < 40);
    check(exec_done, 1'b1);
  endtask
  task automatic run(input logic [3:0] op);
    @(posedge core_clk);
    exec_start <= 1'b1;
    exec_op <= op;
    @(posedge core_clk);
    exec_start <= 1'b0;
    wait_done();
  endtask
  // pins drop at the first matching access, so only one transfer runs
  task automatic dma(input logic i, input logic o, input logic [15:0] a, input logic t);
    int n;
    n = 0;
    @(posedge core_clk);
    dma_in_req_pin <= i;
    dma_out_req_pin <= o;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while ({mem_read_strobe_n, mem_write_strobe_n} !== {i, ~i} && n < 40);
    check(mem_addr, a);
    check(timing_pulse_a, t);
    @(posedge core_clk);
    dma_in_req_pin <= 1'b0;
    dma_out_req_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
  function automatic logic [8:0] calc(input logic [3:0] op, input logic [7:0] a, input logic [7:0] m,
    input logic c);
    case (op)
      4'h0, 4'h8: calc = {c, m};
      4'h1, 4'h9: calc = {c, a | m};
      4'h2, 4'ha: calc = {c, a & m};
      4'h3, 4'hb: calc = {c, a ^ m};
      4'h4, 4'hc: calc = {1'b0, a} + {1'b0, m};
      4'h5, 4'hd: calc = {1'b0, m} + {1'b0, ~a} + 9'h001;
      4'h6: calc = {a[0], 1'b0, a[7:1]};
      4'he: calc = {a[7], a[6:0], 1'b0};
      default: calc = {1'b0, a} + {1'b0, ~m} + 9'h001;
    endcase
  endfunction
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #2_000_000;
    err_total++;
    summarize();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    mem.ram_r[8'h20] = 8'h5a;
    mem.ram_r[8'h40] = 8'h5a;
    for (int op = 0; op < 16; op++) begin
      setr(4'h3, 32'h0000_0020);
      setr(4'h4, 32'h0000_0040);
      // start carry alternates so an untouched carry is visible
      wr(4'h0, {19'h0_0000, op[0], 4'h4, 4'h3, 4'h0});
      wr(4'h3, 32'h0000_00c3);
      run(op[3:0]);
      ev = calc(op[3:0], 8'hc3, 8'h5a, op[0]);
      check(seen_addr, (op[2:0] == 3'b110) ? 16'hffff : (op[3] ? 16'h0040 : 16'h0020));
      rd(4'h3, rv);
      check(rv[7:0], ev[7:0]);
      rd(4'h0, rv);
      check(rv[12], ev[8]);
      wr(4'h4, 32'h0000_0004);
      rd(4'h5, rv);
      check(rv[15:0], (op[3] && op != 14) ? 16'h0041 : 16'h0040);
    end
    check(irq, 1'b0);
    $display("exec test end");
    rd(4'h1, rv);
    wr(4'h2, 32'h0000_0008);
    wr(4'h0, 32'h0000_0651);
    int_req_pin <= 1'b1;
    wait_done();
    int_req_pin <= 1'b0;
    check(seen_addr, 16'hffff);
    rd(4'h0, rv);
    check(rv, 32'h0000_0120);
    rd(4'h3, rv);
    check(rv[15:8], 8'h56);
    check(irq, 1'b1);
    rd(4'h1, rv);
    check(rv[3], 1'b1);
    repeat (2) @(posedge core_clk);
    #1 check(irq, 1'b0);
    $display("irq test end");
    setr(4'h0, 32'h0000_0010);
    mem.ram_r[8'h10] = 8'h77;
    dma(1'b0, 1'b1, 16'h0010, 1'b1);
    dma(1'b1, 1'b0, 16'h0011, 1'b1);
    check(mem.ram_r[8'h11], 8'h3c);
    dma(1'b1, 1'b1, 16'h0012, 1'b1);
    wr(4'h4, 32'h0000_0000);
    rd(4'h5, rv);
    check(rv[15:0], 16'h0013);
    $display("dma test end");
    clear_n <= 1'b0;
    wait_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    #1 check(mem_addr, 16'h0012);
    check(mem_read_strobe_n, 1'b0);
    dma(1'b1, 1'b0, 16'h0013, 1'b0);
    #1 check(mem_addr, 16'h0013);
    clear_n <= 1'b1;
    wait_n <= 1'b1;
    $display("load test end");
    summarize();
  end
endmodule // test_exec_unit
